/* dv/tb.sv */
`timescale 1ns/1ps
// Both ends joined over the link; the bench drives APB and the peer side.
module tb;
   logic pclk;
   logic presetn;
   logic psel, penable, pwrite, pready, pslverr, irq, err;
   logic [3:0] paddr;
   logic [31:0] pwdata, prdata, rd, word_data;
   logic word_valid, word_ready, pkt_commit, pkt_abort;
   logic byte_valid, byte_first, byte_last, byte_ack;
   logic [7:0] byte_data;
   logic [9:0] exp_q[$]; // Expected {first, last, byte} in order.
   logic [9:0] got_q[$]; // Bytes the peer handed out.
   int n_errors, num_checks;
   int cyc = 0; // Free-running cycle count for the ack pattern.
   usb_mac_if link();
   // A small depth keeps pointer wrap within reach of short tests.
   tx_frame_extractor #(.DEPTH(16)) u_tx_frame_extractor (.pclk(pclk),
      .presetn(presetn), .link(link.dev), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq));
   usb_mac_peer u_usb_mac_peer (.pclk(pclk), .presetn(presetn),
      .link(link.host), .word_valid(word_valid), .word_data(word_data),
      .word_ready(word_ready), .pkt_commit(pkt_commit),
      .pkt_abort(pkt_abort), .byte_valid(byte_valid),
      .byte_data(byte_data), .byte_first(byte_first),
      .byte_last(byte_last), .byte_ack(byte_ack));
   txfe_chk u_txfe_chk (.pclk(pclk), .presetn(presetn),
      .usb_valid(link.usb_valid), .usb_data(link.usb_data),
      .usb_ready(link.usb_ready), .usb_commit(link.usb_commit),
      .usb_abort(link.usb_abort), .mac_valid(link.mac_valid),
      .mac_data(link.mac_data), .mac_first(link.mac_first),
      .mac_last(link.mac_last), .mac_ready(link.mac_ready));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////
   // Collect bytes; the peer is stalled one cycle in three.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      byte_ack <= (cyc % 3) != 0;
      if (byte_valid === 1'b1 && byte_ack === 1'b1) begin
         got_q.push_back({byte_first, byte_last, byte_data});
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; an idle cycle follows so psel is never set twice.
   task automatic apb(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for pready.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic regchk(input logic [3:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   // Offer one word and stay until the peer takes it or 64 cycles pass.
   task automatic send_word(input logic [31:0] w);
      word_valid <= 1'b1;
      word_data <= w;
      for (int i = 0; i < 64; i++) begin
         @(posedge pclk);
         if (word_ready === 1'b1) break;
      end
   endtask
   // Close a packet once the peer stage is empty.
   task automatic pkt_end(input logic ab);
      word_valid <= 1'b0;
      for (int i = 0; i < 64; i++) begin
         @(posedge pclk);
         if (word_ready === 1'b1) break;
      end
      pkt_commit <= !ab;
      pkt_abort <= ab;
      @(posedge pclk);
      pkt_commit <= 1'b0;
      pkt_abort <= 1'b0;
      @(posedge pclk);
   endtask
   // One buffer as one packet; filler lanes carry 8'hee.
   task automatic send_buf(input int ofs, input int size, input logic fs,
      input logic ls, input int flen, input logic [31:0] bx,
      input logic ab);
      logic [31:0] w;
      int idx;
      send_word({14'h0, 2'(ofs), 2'h0, fs, ls, 1'b0, 11'(size)});
      send_word(32'(flen) ^ bx);
      for (int n = 0; n < (ofs + size + 3) / 4; n++) begin
         for (int l = 0; l < 4; l++) begin
            idx = n * 4 + l - ofs;
            w[l*8 +: 8] = (idx >= 0 && idx < size) ? 8'(size * 16 + idx)
               : 8'hee;
            if (!ab && idx >= 0 && idx < size) begin
               exp_q.push_back({fs && idx == 0, ls && idx == size - 1,
                  w[l*8 +: 8]});
            end
         end
         send_word(w);
      end
      pkt_end(ab);
   endtask
   // Compare the byte stream, then irq and the clear-on-read status.
   task automatic drain(input logic [31:0] st, input logic ir);
      for (int i = 0; i < 600 && got_q.size() < exp_q.size(); i++) begin
         @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
      check(32'(got_q.size()), 32'(exp_q.size()));
      while (exp_q.size() > 0 && got_q.size() > 0) begin
         check(32'(got_q.pop_front()), 32'(exp_q.pop_front()));
      end
      check(32'(irq), 32'(ir));
      regchk(txfe_pkg::REG_STATUS, st);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0);
      regchk(txfe_pkg::REG_STATUS, 32'h0);
      exp_q.delete();
      got_q.delete();
   endtask
   task automatic wrap_up();
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      wrap_up();
   end
   initial begin
      {presetn, psel, penable, pwrite, word_valid, pkt_commit} = 6'h0;
      pkt_abort = 1'b0;
      {paddr, pwdata, word_data} = 68'h0;
      {n_errors, num_checks} = 64'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      // Register reset values, access kinds and an unmapped place.
      regchk(txfe_pkg::REG_CTRL, 32'h1);
      regchk(txfe_pkg::REG_MASK, 32'h0);
      regchk(txfe_pkg::REG_STATUS, 32'h0);
      apb(1'b1, txfe_pkg::REG_LEVEL, 32'hff);
      regchk(txfe_pkg::REG_LEVEL, 32'h0);
      apb(1'b1, txfe_pkg::REG_CTRL, 32'h0);
      regchk(txfe_pkg::REG_CTRL, 32'h0);
      apb(1'b1, txfe_pkg::REG_CTRL, 32'h1);
      regchk(4'h2, 32'h0);
      check(32'(err), 32'h1);
      // Every start offset, back to back, with the interrupt masked.
      for (int o = 0; o < 4; o++) begin
         send_buf(o, 5, 1'b1, 1'b1, 5, 32'h0, 1'b0);
      end
      drain(32'h2, 1'b0);
      apb(1'b1, txfe_pkg::REG_MASK, 32'h3);
      // Two segments; only the checksum bit differs in word B.
      send_buf(3, 6, 1'b1, 1'b0, 10, 32'h4000, 1'b0);
      send_buf(0, 4, 1'b0, 1'b1, 10, 32'h0, 1'b0);
      drain(32'h2, 1'b1);
      // An errored packet is rewound and a good one follows.
      send_buf(1, 7, 1'b1, 1'b1, 7, 32'h0, 1'b1);
      send_buf(2, 7, 1'b1, 1'b1, 7, 32'h0, 1'b0);
      drain(32'h2, 1'b1);
      // Word B differs in a bit other than the checksum bit.
      send_buf(0, 4, 1'b1, 1'b0, 8, 32'h0, 1'b0);
      send_buf(0, 4, 1'b0, 1'b1, 8, 32'h2000, 1'b0);
      drain(32'h3, 1'b1);
      // Declared frame length disagrees with the data sent.
      send_buf(1, 3, 1'b1, 1'b1, 4, 32'h0, 1'b0);
      drain(32'h3, 1'b1);
      // Parser held off: the words wait in the FIFO until enabled.
      apb(1'b1, txfe_pkg::REG_CTRL, 32'h0);
      send_buf(0, 4, 1'b1, 1'b1, 4, 32'h0, 1'b0);
      regchk(txfe_pkg::REG_LEVEL, 32'h3);
      apb(1'b1, txfe_pkg::REG_CTRL, 32'h1);
      drain(32'h2, 1'b1);
      wrap_up();
   end
endmodule

/* dv/txfe_chk.sv */
`timescale 1ns/1ps
// Link watcher: sees only the signals of the interface between the ends.
module txfe_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic usb_valid,
   input wire logic [31:0] usb_data,
   input wire logic usb_ready,
   input wire logic usb_commit,
   input wire logic usb_abort,
   input wire logic mac_valid,
   input wire logic [7:0] mac_data,
   input wire logic mac_first,
   input wire logic mac_last,
   input wire logic mac_ready
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic take;          // A frame byte moves this cycle.
   logic in_frame;      // A frame has begun and its last byte is still due.
   logic next_in_frame;
   logic seen_commit;   // Some packet has been committed since reset.
   logic next_seen_commit;
   assign take = mac_valid & mac_ready;
   ////////////////////////////////////////////////////////////////////
   // Frame and commit tracking, so order can be judged across cycles.
   always_comb begin
      next_in_frame = in_frame;
      next_seen_commit = seen_commit | usb_commit;
      if (take) begin
         next_in_frame = !mac_last;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_frame <= 1'b0;
         seen_commit <= 1'b0;
      end else begin
         in_frame <= next_in_frame;
         seen_commit <= next_seen_commit;
      end
   end
   ////////////////////////////////////////////////////////////////////
   property p_mac_hold;
      mac_valid && !mac_ready |=> mac_valid && $stable(mac_data)
         && $stable({mac_first, mac_last});
   endproperty
   property p_first_open;
      take && mac_first |-> !in_frame;
   endproperty
   property p_mid_open;
      take && !mac_first |-> in_frame;
   endproperty
   property p_usb_hold;
      usb_valid && !usb_ready |=> usb_valid && $stable(usb_data);
   endproperty
   property p_commit_alone;
      usb_commit |-> !usb_valid && !usb_abort;
   endproperty
   property p_commit_pulse;
      $rose(usb_commit) |=> !usb_commit [*2];
   endproperty
   property p_abort_pulse;
      usb_abort |=> !usb_abort;
   endproperty
   // No frame byte is offered before the first commit since reset.
   property p_needs_commit;
      mac_valid |-> seen_commit;
   endproperty
   a_mac_hold: assert property (p_mac_hold)
      else $error("frame byte changed before it was taken");
   a_first_open: assert property (p_first_open)
      else $error("first byte inside an open frame");
   a_mid_open: assert property (p_mid_open)
      else $error("frame byte outside any frame");
   a_usb_hold: assert property (p_usb_hold)
      else $error("packet word changed before it was taken");
   a_commit_alone: assert property (p_commit_alone)
      else $error("commit shares a cycle with a word or abort");
   a_commit_pulse: assert property (p_commit_pulse)
      else $error("commit longer than one cycle");
   a_abort_pulse: assert property (p_abort_pulse)
      else $error("abort longer than one cycle");
   a_needs_commit: assert property (p_needs_commit)
      else $error("frame byte before any commit");
   c_last: cover property (take && mac_last);
   c_abort: cover property (usb_abort);
   c_stall: cover property (mac_valid && !mac_ready);
endmodule

/* logic/tx_frame_extractor.sv */
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Transmit extractor: stores packets, parses buffers, sends bytes.
module tx_frame_extractor #(
   parameter int DEPTH = txfe_pkg::FIFO_WORDS,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic pclk,
   input wire logic presetn,
   usb_mac_if.dev link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [3:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   logic rd_valid;                  // Committed word waiting.
   logic [31:0] rd_data;            // Word at read pointer.
   logic [AW:0] used;               // Words held.
   logic rd_pop;                    // Take the word.
   txfe_pkg::parse_state_t state;   // Parser state.
   txfe_pkg::parse_state_t next_state;
   logic [31:0] cmd_a;              // Current command A.
   logic [31:0] next_cmd_a;
   logic [31:0] ref_b;              // Command B of the open frame.
   logic [31:0] next_ref_b;
   logic in_frame;                  // A frame is open.
   logic next_in_frame;
   logic [11:0] frame_sum;          // Sizes summed so far.
   logic [11:0] next_frame_sum;
   logic [10:0] remain;             // Buffer bytes still to send.
   logic [10:0] next_remain;
   logic [31:0] hold;               // Word being split into bytes.
   logic [31:0] next_hold;
   logic [1:0] lane;                // Byte lane inside hold.
   logic [1:0] next_lane;
   logic first_word;                // Next fetch is first data word.
   logic next_first_word;
   logic first_pend;                // Next byte opens a frame.
   logic next_first_pend;
   logic ready_q;
   logic next_ready_q;
   logic valid_q;
   logic next_valid_q;
   logic [7:0] data_q;
   logic [7:0] next_data_q;
   logic first_q;
   logic next_first_q;
   logic last_q;
   logic next_last_q;
   logic err_ev;                    // Error event this cycle.
   logic done_ev;                   // Frame finished this cycle.
   logic enable;                    // Parser runs.
   logic [1:0] status;              // Sticky events.
   logic [1:0] mask;                // Interrupt mask.
   logic [1:0] next_status;
   logic [1:0] next_mask;
   logic next_enable;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_irq;
   logic [11:0] total;              // Sum including this buffer.

   tx_word_fifo #(.WIDTH(32), .DEPTH(DEPTH), .AW(AW)) fifo (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(link.usb_valid && ready_q),
      .wr_data(link.usb_data),
      .commit(link.usb_commit),
      .abort(link.usb_abort),
      .rd_pop(rd_pop),
      .rd_valid(rd_valid),
      .rd_data(rd_data),
      .used(used)
   );

   assign link.usb_ready = ready_q;
   assign link.mac_valid = valid_q;
   assign link.mac_data = data_q;
   assign link.mac_first = first_q;
   assign link.mac_last = last_q;

   ////////////////////////////////////////////////////////////////////
   // Read-side parser. The byte stage is a single register, so a new
   // byte loads only when the stage is empty or being taken.
   always_comb begin
      next_state = state;
      next_cmd_a = cmd_a;
      next_ref_b = ref_b;
      next_in_frame = in_frame;
      next_frame_sum = frame_sum;
      next_remain = remain;
      next_hold = hold;
      next_lane = lane;
      next_first_word = first_word;
      next_first_pend = first_pend;
      next_valid_q = valid_q && !link.mac_ready;
      next_data_q = data_q;
      next_first_q = first_q;
      next_last_q = last_q;
      rd_pop = 1'b0;
      err_ev = 1'b0;
      done_ev = 1'b0;
      total = frame_sum + {1'b0, cmd_a[txfe_pkg::SIZE_MSB:0]};
      next_ready_q = used <= (AW+1)'(DEPTH - 2);
      case (state)
         txfe_pkg::ST_CMD_A: begin
            if (rd_valid && enable) begin
               rd_pop = 1'b1;
               next_cmd_a = rd_data;
               next_state = txfe_pkg::ST_CMD_B;
            end
         end
         txfe_pkg::ST_CMD_B: begin
            if (rd_valid) begin
               rd_pop = 1'b1;
               if (cmd_a[txfe_pkg::FIRST_BIT]) begin
                  next_ref_b = rd_data;
                  next_frame_sum = 12'(cmd_a[txfe_pkg::SIZE_MSB:0]);
                  next_first_pend = 1'b1;
                  total = 12'(cmd_a[txfe_pkg::SIZE_MSB:0]);
                  err_ev = in_frame;
               end else begin
                  next_frame_sum = total;
                  err_ev = !in_frame ||
                     ((rd_data ^ ref_b) &
                      ~(32'h1 << txfe_pkg::CSUM_REQ_BIT)) != 32'h0;
               end
               next_in_frame = !cmd_a[txfe_pkg::LAST_BIT];
               if (cmd_a[txfe_pkg::LAST_BIT] && total !=
                   {1'b0, rd_data[txfe_pkg::SIZE_MSB:0]}) begin
                  err_ev = 1'b1;
               end
               next_remain = cmd_a[txfe_pkg::SIZE_MSB:0];
               next_first_word = 1'b1;
               next_state = cmd_a[txfe_pkg::SIZE_MSB:0] == 11'h0 ?
                  txfe_pkg::ST_CMD_A : txfe_pkg::ST_FETCH;
            end
         end
         txfe_pkg::ST_FETCH: begin
            if (rd_valid) begin
               rd_pop = 1'b1;
               next_hold = rd_data;
               next_lane = first_word ?
                  cmd_a[txfe_pkg::OFS_LSB+1:txfe_pkg::OFS_LSB] : 2'h0;
               next_first_word = 1'b0;
               next_state = txfe_pkg::ST_EMIT;
            end
         end
         txfe_pkg::ST_EMIT: begin
            if (!valid_q || link.mac_ready) begin
               next_valid_q = 1'b1;
               next_data_q = hold[{lane, 3'h0} +: 8];
               next_first_q = first_pend;
               next_first_pend = 1'b0;
               next_remain = remain - 11'h1;
               next_last_q = remain == 11'h1 &&
                  cmd_a[txfe_pkg::LAST_BIT];
               done_ev = next_last_q;
               next_lane = lane + 2'h1;
               if (remain == 11'h1) begin
                  next_state = txfe_pkg::ST_CMD_A;
               end else if (lane == 2'h3) begin
                  next_state = txfe_pkg::ST_FETCH;
               end
            end
         end
         default: begin
            next_state = txfe_pkg::ST_CMD_A;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= txfe_pkg::ST_CMD_A;
         cmd_a <= 32'h0;
         ref_b <= 32'h0;
         in_frame <= 1'b0;
         frame_sum <= 12'h0;
         remain <= 11'h0;
         hold <= 32'h0;
         lane <= 2'h0;
         first_word <= 1'b0;
         first_pend <= 1'b0;
         ready_q <= 1'b0;
         valid_q <= 1'b0;
         data_q <= 8'h0;
         first_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         state <= next_state;
         cmd_a <= next_cmd_a;
         ref_b <= next_ref_b;
         in_frame <= next_in_frame;
         frame_sum <= next_frame_sum;
         remain <= next_remain;
         hold <= next_hold;
         lane <= next_lane;
         first_word <= next_first_word;
         first_pend <= next_first_pend;
         ready_q <= next_ready_q;
         valid_q <= next_valid_q;
         data_q <= next_data_q;
         first_q <= next_first_q;
         last_q <= next_last_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB slave, no wait states. Read data is latched in the setup
   // cycle, and a status read clears only the bits it returned, so an
   // event arriving between setup and access is not lost.
   always_comb begin
      next_enable = enable;
      next_mask = mask;
      next_prdata = prdata;
      next_pready = psel && !penable;
      next_pslverr = 1'b0;
      next_status = status;
      if (psel && penable && pready && !pwrite &&
          paddr == txfe_pkg::REG_STATUS) begin
         next_status = status & ~prdata[1:0];
      end
      // Hardware set wins over the read clear.
      next_status[txfe_pkg::ST_TX_ERR] =
         next_status[txfe_pkg::ST_TX_ERR] | err_ev;
      next_status[txfe_pkg::ST_FRAME_DONE] =
         next_status[txfe_pkg::ST_FRAME_DONE] | done_ev;
      if (psel && !penable) begin
         next_prdata = 32'h0;
         case (paddr)
            txfe_pkg::REG_CTRL: next_prdata = {31'h0, enable};
            txfe_pkg::REG_STATUS: next_prdata = {30'h0, status};
            txfe_pkg::REG_MASK: next_prdata = {30'h0, mask};
            txfe_pkg::REG_LEVEL: next_prdata = 32'(used);
            default: next_pslverr = 1'b1;
         endcase
      end
      // Writes land at the access edge, when pready is seen high.
      if (psel && penable && pready && pwrite) begin
         if (paddr == txfe_pkg::REG_CTRL) begin
            next_enable = pwdata[0];
         end else if (paddr == txfe_pkg::REG_MASK) begin
            next_mask = pwdata[1:0];
         end
      end
      next_irq = (next_status & next_mask) != 2'h0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable <= txfe_pkg::CTRL_RESET;
         mask <= txfe_pkg::MASK_RESET;
         status <= 2'h0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
      end else begin
         enable <= next_enable;
         mask <= next_mask;
         status <= next_status;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         irq <= next_irq;
      end
   end
endmodule

/* logic/tx_word_fifo.sv */
`timescale 1ns/1ps
// Word FIFO with a rewindable write side; only committed words are
// visible to the reader.
module tx_word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = txfe_pkg::FIFO_WORDS,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic commit,
   input wire logic abort,
   input wire logic rd_pop,
   output logic rd_valid,
   output logic [WIDTH-1:0] rd_data,
   output logic [AW:0] used
);
   logic [WIDTH-1:0] mem [DEPTH];  // Storage array.
   logic [AW:0] wr_ptr;            // Running write pointer.
   logic [AW:0] head_ptr;          // Committed head pointer.
   logic [AW:0] rd_ptr;            // Read pointer.
   logic [AW:0] next_wr_ptr;
   logic [AW:0] next_head_ptr;
   logic [AW:0] next_rd_ptr;

   ////////////////////////////////////////////////////////////////////
   // Reader sees committed words only, so a rewind never takes back
   // anything already parsed.
   assign rd_valid = rd_ptr != head_ptr;
   assign rd_data = mem[rd_ptr[AW-1:0]];
   assign used = wr_ptr - rd_ptr;

   // Pointer updates; an abort wins over a write in the same cycle.
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_head_ptr = head_ptr;
      next_rd_ptr = rd_ptr;
      if (abort) begin
         next_wr_ptr = head_ptr;
      end else if (wr_en) begin
         next_wr_ptr = wr_ptr + 1'b1;
      end
      // Commit publishes everything written so far.
      if (commit && !abort) begin
         next_head_ptr = wr_ptr;
      end
      if (rd_pop && rd_valid) begin
         next_rd_ptr = rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= '0;
         head_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         head_ptr <= next_head_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge pclk) begin
      if (wr_en && !abort) begin
         mem[wr_ptr[AW-1:0]] <= wr_data;
      end
   end
endmodule

/* logic/txfe_pkg.sv */
package txfe_pkg;
   // Storage size in bytes and the word geometry derived from it.
   localparam int FIFO_BYTES = 8192;
   localparam int WORD_BYTES = 4;
   localparam int FIFO_WORDS = FIFO_BYTES / WORD_BYTES;
   // Command word field positions.
   localparam int OFS_LSB = 16;
   localparam int FIRST_BIT = 13;
   localparam int LAST_BIT = 12;
   localparam int SIZE_MSB = 10;
   localparam int CSUM_REQ_BIT = 14;
   // Register byte offsets on the APB slave.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_MASK = 4'h8;
   localparam logic [3:0] REG_LEVEL = 4'hc;
   // Status bit positions and the CTRL and MASK reset values.
   localparam int ST_TX_ERR = 0;
   localparam int ST_FRAME_DONE = 1;
   localparam logic CTRL_RESET = 1'b1;
   localparam logic [1:0] MASK_RESET = 2'h0;
   // Read-side parser states.
   typedef enum logic [3:0] {
      ST_CMD_A = 4'h1,
      ST_CMD_B = 4'h2,
      ST_FETCH = 4'h4,
      ST_EMIT = 4'h8
   } parse_state_t;
endpackage

/* logic/usb_mac_if.sv */
`timescale 1ns/1ps
// Link between the transmit extractor and the USB receive unit and
// MAC transmit interface that surround it.
interface usb_mac_if;
   logic usb_valid;        // Packet word offered.
   logic [31:0] usb_data;  // Packet word, stored as is.
   logic usb_ready;        // Extractor can take a word.
   logic usb_commit;       // Packet good, keep it.
   logic usb_abort;        // Packet errored, rewind it.
   logic mac_valid;        // Frame byte offered.
   logic [7:0] mac_data;   // Frame byte.
   logic mac_first;        // First byte of a frame.
   logic mac_last;         // Last byte of a frame.
   logic mac_ready;        // MAC side takes the byte.

   // Extractor end.
   modport dev (
      input usb_valid, usb_data, usb_commit, usb_abort, mac_ready,
      output usb_ready, mac_valid, mac_data, mac_first, mac_last
   );
   // Surrounding USB and MAC end.
   modport host (
      output usb_valid, usb_data, usb_commit, usb_abort, mac_ready,
      input usb_ready, mac_valid, mac_data, mac_first, mac_last
   );
endinterface

/* logic/usb_mac_peer.sv */
`timescale 1ns/1ps
// Far end: feeds packet words in, collects frame bytes out.
module usb_mac_peer (
   input wire logic pclk,
   input wire logic presetn,
   usb_mac_if.host link,
   input wire logic word_valid,
   input wire logic [31:0] word_data,
   output logic word_ready,
   input wire logic pkt_commit,
   input wire logic pkt_abort,
   output logic byte_valid,
   output logic [7:0] byte_data,
   output logic byte_first,
   output logic byte_last,
   input wire logic byte_ack
);
   logic usb_valid_q;
   logic [31:0] usb_data_q;
   logic commit_q;
   logic abort_q;
   logic mac_ready_q;
   logic next_usb_valid;
   logic [31:0] next_usb_data;
   logic next_word_ready;
   logic next_commit;
   logic next_abort;
   logic next_byte_valid;
   logic [7:0] next_byte_data;
   logic next_byte_first;
   logic next_byte_last;
   logic next_mac_ready;

   assign link.usb_valid = usb_valid_q;
   assign link.usb_data = usb_data_q;
   assign link.usb_commit = commit_q;
   assign link.usb_abort = abort_q;
   assign link.mac_ready = mac_ready_q;

   ////////////////////////////////////////////////////////////////////
   // One-word stage toward the extractor and one-byte stage from it.
   // Half throughput is traded for outputs that all come from flops.
   always_comb begin
      next_usb_valid = usb_valid_q && !link.usb_ready;
      next_usb_data = usb_data_q;
      if (word_valid && word_ready) begin
         next_usb_valid = 1'b1;
         next_usb_data = word_data;
      end
      next_word_ready = !next_usb_valid;
      // Packet end marks go out only once the stage is empty.
      next_commit = pkt_commit && word_ready && !word_valid;
      next_abort = pkt_abort && word_ready && !word_valid;
      next_byte_valid = byte_valid && !byte_ack;
      next_byte_data = byte_data;
      next_byte_first = byte_first;
      next_byte_last = byte_last;
      if (link.mac_valid && mac_ready_q) begin
         next_byte_valid = 1'b1;
         next_byte_data = link.mac_data;
         next_byte_first = link.mac_first;
         next_byte_last = link.mac_last;
      end
      next_mac_ready = !next_byte_valid;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_valid_q <= 1'b0;
         usb_data_q <= 32'h0;
         word_ready <= 1'b0;
         commit_q <= 1'b0;
         abort_q <= 1'b0;
         byte_valid <= 1'b0;
         byte_data <= 8'h0;
         byte_first <= 1'b0;
         byte_last <= 1'b0;
         mac_ready_q <= 1'b0;
      end else begin
         usb_valid_q <= next_usb_valid;
         usb_data_q <= next_usb_data;
         word_ready <= next_word_ready;
         commit_q <= next_commit;
         abort_q <= next_abort;
         byte_valid <= next_byte_valid;
         byte_data <= next_byte_data;
         byte_first <= next_byte_first;
         byte_last <= next_byte_last;
         mac_ready_q <= next_mac_ready;
      end
   end
endmodule
